// ==== inc/abx_pkg.sv ====
/*
 * constants, encodings and the state layout of the accumulator
 * execution block.
 * assumes nothing beyond a SystemVerilog compiler; has no logic.
 */
`default_nettype none

package abx_pkg;

   // ****************************************
   // register map, byte addresses on apb
   // ****************************************
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_ACC = 8'h04;
   localparam logic [7:0] REG_FLAGS = 8'h08;
   localparam logic [7:0] REG_SKIPS = 8'h0c;

   // ****************************************
   // field positions
   // ****************************************
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_PRESC_BIT = 1;
   localparam int FLAG_C_BIT = 0;
   localparam int FLAG_HALF_CARRY_BIT = 1;
   localparam int FLAG_Z_BIT = 2;

   // ****************************************
   // reset values and fixed addresses
   // ****************************************
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic CTRL_EN_RST = 1'b1;
   localparam logic CTRL_PRESC_RST = 1'b0;
   localparam logic [2:0] FLAGS_RST = 3'h0;
   localparam logic [15:0] SKIPS_RST = 16'h0000;
   // file address of timer_count_reg
   localparam logic [6:0] TIMER_ADDR = 7'h01;

   // ****************************************
   // operations and sequencing
   // ****************************************
   typedef enum logic [2:0] {
      ADD_IMMEDIATE_TO_ACC = 3'b000,
      ADD_ACC_AND_REG = 3'b001,
      AND_IMMEDIATE_WITH_ACC = 3'b010,
      AND_ACC_WITH_REG = 3'b011,
      SINGLE_BIT_CLEAR = 3'b100,
      SINGLE_BIT_SET = 3'b101,
      TEST_SKIP_WHEN_ZERO = 3'b110,
      TEST_SKIP_WHEN_ONE = 3'b111
   } abx_op_t;

   // run: execute; discard: next instruction becomes a no-op
   typedef enum logic [0:0] {
      SEQ_RUN = 1'b0,
      SEQ_DISCARD = 1'b1
   } abx_seq_t;

   typedef struct packed {
      logic [7:0] acc;
      logic carry;
      logic halfCarryFlag;
      logic zero;
      logic execEn;
      logic prescAssigned;
      abx_seq_t seq;
      logic wrEn;
      logic [6:0] wrAddr;
      logic [7:0] wrData;
      logic prescClr;
      logic nopSlot;
      logic [15:0] skips;
      logic [31:0] prdata;
      logic pslverr;
   } abx_state_t;

endpackage

`default_nettype wire

// ==== inc/abx_alu_if.sv ====
/*
 * operand and result bundle between the execution core and its alu.
 * assumes the alu answers combinationally within the same cycle.
 */
`timescale 1ns/1ps
`default_nettype none

interface abx_alu_if;
   abx_pkg::abx_op_t op;
   logic [7:0] opA;
   logic [7:0] opB;
   logic [2:0] bitSel;
   logic [7:0] res;
   logic carry;
   logic halfCarry;
   logic zero;
   logic bitVal;

   modport alu (
      input op, opA, opB, bitSel,
      output res, carry, halfCarry, zero, bitVal
   );

   modport core (
      output op, opA, opB, bitSel,
      input res, carry, halfCarry, zero, bitVal
   );
endinterface

`default_nettype wire

// ==== design/abx_alu.sv ====
/*
 * combinational alu: add, and, bit clear, bit set and bit test.
 * assumes opB already holds the immediate or the file operand.
 */
`timescale 1ns/1ps
`default_nettype none

module abx_alu (
   // operands in, results out
   abx_alu_if.alu a
);

   logic [8:0] sum9;
   logic [4:0] low5;
   logic [7:0] mask;

   // ****************************************
   // datapath
   // ****************************************

   // nine and five bit sums expose carry out of bit 7 and bit 3
   always_comb begin
      sum9 = {1'b0, a.opA} + {1'b0, a.opB};
      low5 = {1'b0, a.opA[3:0]} + {1'b0, a.opB[3:0]};
      mask = 8'h01 << a.bitSel;
      a.carry = sum9[8];
      a.halfCarry = low5[4];
      a.bitVal = a.opB[a.bitSel];
      case (a.op)
         abx_pkg::ADD_IMMEDIATE_TO_ACC,
         abx_pkg::ADD_ACC_AND_REG: a.res = sum9[7:0];
         abx_pkg::AND_IMMEDIATE_WITH_ACC,
         abx_pkg::AND_ACC_WITH_REG: a.res = a.opA & a.opB;
         abx_pkg::SINGLE_BIT_CLEAR: a.res = a.opB & ~mask;
         abx_pkg::SINGLE_BIT_SET: a.res = a.opB | mask;
         default: a.res = a.opB;
      endcase
      a.zero = (a.res == 8'h00);
   end

endmodule

`default_nettype wire

// ==== design/abx_exec.sv ====
/*
 * execution core for eight byte and bit instructions: accumulator,
 * flags, file register write-back, skip sequencing and an apb slave.
 * assumes a decoder that presents one instruction with instValid,
 * a register file that returns fileRdData for fileRdAddr in the
 * same cycle, and a sequencer that follows nopSlot.
 * apb answers with no wait states; ce low freezes every flop.
 */
// Notes on behaviour
// - add immediate adds byte to accumulator, result to accumulator, sets carry, half carry, zero.
// - add register adds accumulator and file register, sets carry, half carry, zero.
// - destination bit 0 writes accumulator, 1 writes the file register back.
// - and immediate ands byte into accumulator, changes only Z.
// - and register ands accumulator with file register to destination, only Z.
// - bit clear zeroes one bit of a file register, flags unchanged.
// - bit set forces one bit of a file register high, flags unchanged.
// - skip-when-zero: zero bit discards next instruction as a no-op.
// - skip-when-one: one bit discards next instruction as a no-op.
// - read-modify of an io register uses pin values, not the latch.
// - writing the timer register clears the prescaler when assigned to it.
`timescale 1ns/1ps
`default_nettype none

module abx_exec (
   // clock, reset, enable
   input wire logic core_clk,
   input wire logic rst,
   input wire logic ce,

   // instruction from the decoder
   input wire logic instValid,
   output logic instReady,
   input wire abx_pkg::abx_op_t instOp,
   input wire logic [7:0] instImm,
   input wire logic [6:0] instAddr,
   input wire logic instDest,
   input wire logic [2:0] instBit,

   // register file read side
   output logic [6:0] fileRdAddr,
   input wire logic [7:0] fileRdData,
   input wire logic fileIsIo,
   input wire logic [7:0] ioPinData,

   // register file write side
   output logic fileWrEn,
   output logic [6:0] fileWrAddr,
   output logic [7:0] fileWrData,

   // sequencer and timer
   output logic nopSlot,
   output logic skipPending,
   output logic prescClr,

   // accumulator and flags
   output logic [7:0] accOut,
   output logic carryOut,
   output logic halfCarryOut,
   output logic zeroOut,

   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);

   // ****************************************
   // state
   // ****************************************
   localparam abx_pkg::abx_state_t STATE_RST = '{
      acc: abx_pkg::ACC_RST,
      carry: abx_pkg::FLAGS_RST[abx_pkg::FLAG_C_BIT],
      halfCarryFlag: abx_pkg::FLAGS_RST[abx_pkg::FLAG_HALF_CARRY_BIT],
      zero: abx_pkg::FLAGS_RST[abx_pkg::FLAG_Z_BIT],
      execEn: abx_pkg::CTRL_EN_RST,
      prescAssigned: abx_pkg::CTRL_PRESC_RST,
      seq: abx_pkg::SEQ_RUN,
      wrEn: 1'b0,
      wrAddr: 7'h00,
      wrData: 8'h00,
      prescClr: 1'b0,
      nopSlot: 1'b0,
      skips: abx_pkg::SKIPS_RST,
      prdata: 32'h00000000,
      pslverr: 1'b0
   };

   // whole state in one register, next value built below
   abx_pkg::abx_state_t s_q;
   abx_pkg::abx_state_t s_d;

   // operand and result bundle for the alu
   abx_alu_if aluBus ();

   // combinational glue
   logic take;
   logic [7:0] fileOperand;
   logic regOp;
   logic apbSetup;
   logic apbWrite;
   logic [31:0] rdMux;
   logic rdErr;

   // ****************************************
   // alu
   // ****************************************
   abx_alu u_alu (
      .a (aluBus.alu)
   );

   // io registers are read back from the pins so that an input
   // pulled low externally is written back as it is seen
   assign fileOperand = fileIsIo ? ioPinData : fileRdData;

   // immediate forms take the literal, the rest the file operand
   always_comb begin
      regOp = (instOp != abx_pkg::ADD_IMMEDIATE_TO_ACC) &&
              (instOp != abx_pkg::AND_IMMEDIATE_WITH_ACC);
      aluBus.op = instOp;
      aluBus.opA = s_q.acc;
      aluBus.opB = regOp ? fileOperand : instImm;
      aluBus.bitSel = instBit;
   end

   // ****************************************
   // handshakes and outputs
   // ****************************************

   // ready only gates on the enable bit; skip slots still consume
   assign instReady = s_q.execEn;
   assign take = instValid && s_q.execEn;
   assign fileRdAddr = instAddr;

   // write port straight from flops, so the file sees no glitches
   assign fileWrEn = s_q.wrEn;
   assign fileWrAddr = s_q.wrAddr;
   assign fileWrData = s_q.wrData;

   // nopSlot and prescClr pulse for one cycle each; skipPending holds until the discarded slot
   assign nopSlot = s_q.nopSlot;
   assign skipPending = (s_q.seq == abx_pkg::SEQ_DISCARD);
   assign prescClr = s_q.prescClr;

   // accumulator and flags as registered
   assign accOut = s_q.acc;
   assign carryOut = s_q.carry;
   assign halfCarryOut = s_q.halfCarryFlag;
   assign zeroOut = s_q.zero;

   // zero wait states: read data is captured in the setup cycle
   assign apbSetup = psel && !penable;
   assign apbWrite = psel && penable && pwrite;
   assign pready = psel && penable;
   assign prdata = s_q.prdata;
   assign pslverr = s_q.pslverr;

   // ****************************************
   // apb read decode
   // ****************************************

   // unmapped or misaligned words read zero and flag an error
   always_comb begin
      rdMux = 32'h00000000;
      rdErr = 1'b0;
      case (paddr)
         abx_pkg::REG_CTRL: begin
            rdMux[abx_pkg::CTRL_EN_BIT] = s_q.execEn;
            rdMux[abx_pkg::CTRL_PRESC_BIT] = s_q.prescAssigned;
         end
         abx_pkg::REG_ACC: rdMux[7:0] = s_q.acc;
         abx_pkg::REG_FLAGS: begin
            rdMux[abx_pkg::FLAG_C_BIT] = s_q.carry;
            rdMux[abx_pkg::FLAG_HALF_CARRY_BIT] = s_q.halfCarryFlag;
            rdMux[abx_pkg::FLAG_Z_BIT] = s_q.zero;
         end
         abx_pkg::REG_SKIPS: rdMux[15:0] = s_q.skips;
         default: rdErr = 1'b1;
      endcase
   end

   // ****************************************
   // next state
   // ****************************************
   // pulses default low; every other field holds unless written
   always_comb begin
      s_d = s_q;
      s_d.wrEn = 1'b0;
      s_d.prescClr = 1'b0;
      s_d.nopSlot = 1'b0;

      // apb side first, so a same-cycle instruction result wins
      if (apbSetup) begin
         s_d.prdata = rdMux;
         s_d.pslverr = rdErr;
      end
      // access phase write; skips and unmapped words ignore it
      if (apbWrite) begin
         case (paddr)
            abx_pkg::REG_CTRL: begin
               s_d.execEn = pwdata[abx_pkg::CTRL_EN_BIT];
               s_d.prescAssigned = pwdata[abx_pkg::CTRL_PRESC_BIT];
            end
            abx_pkg::REG_ACC: s_d.acc = pwdata[7:0];
            abx_pkg::REG_FLAGS: begin
               s_d.carry = pwdata[abx_pkg::FLAG_C_BIT];
               s_d.halfCarryFlag = pwdata[abx_pkg::FLAG_HALF_CARRY_BIT];
               s_d.zero = pwdata[abx_pkg::FLAG_Z_BIT];
            end
            default: s_d.skips = s_q.skips;
         endcase
      end

      // instruction side, last so it overrides a bus write
      if (take) begin
         case (s_q.seq)
            abx_pkg::SEQ_DISCARD: begin
               // second cycle of a taken skip: only the nop pulse and the skip count
               s_d.nopSlot = 1'b1;
               s_d.seq = abx_pkg::SEQ_RUN;
               s_d.skips = s_q.skips + 16'h0001;
            end
            abx_pkg::SEQ_RUN: begin
               case (instOp)
                  abx_pkg::ADD_IMMEDIATE_TO_ACC: begin
                     s_d.acc = aluBus.res;
                     s_d.carry = aluBus.carry;
                     s_d.halfCarryFlag = aluBus.halfCarry;
                     s_d.zero = aluBus.zero;
                  end
                  abx_pkg::ADD_ACC_AND_REG: begin
                     s_d.carry = aluBus.carry;
                     s_d.halfCarryFlag = aluBus.halfCarry;
                     s_d.zero = aluBus.zero;
                     if (!instDest) begin
                        s_d.acc = aluBus.res;
                     end else begin
                        s_d.wrEn = 1'b1;
                     end
                  end
                  abx_pkg::AND_IMMEDIATE_WITH_ACC: begin
                     s_d.acc = aluBus.res;
                     s_d.zero = aluBus.zero;
                  end
                  abx_pkg::AND_ACC_WITH_REG: begin
                     s_d.zero = aluBus.zero;
                     if (!instDest) begin
                        s_d.acc = aluBus.res;
                     end else begin
                        s_d.wrEn = 1'b1;
                     end
                  end
                  abx_pkg::SINGLE_BIT_CLEAR,
                  abx_pkg::SINGLE_BIT_SET: begin
                     s_d.wrEn = 1'b1;
                  end
                  abx_pkg::TEST_SKIP_WHEN_ZERO: begin
                     if (!aluBus.bitVal) begin
                        s_d.seq = abx_pkg::SEQ_DISCARD;
                     end
                  end
                  abx_pkg::TEST_SKIP_WHEN_ONE: begin
                     if (aluBus.bitVal) begin
                        s_d.seq = abx_pkg::SEQ_DISCARD;
                     end
                  end
                  default: s_d.seq = abx_pkg::SEQ_RUN;
               endcase
               // a file write-back to the timer resets its prescaler when it is assigned
               if (s_d.wrEn) begin
                  s_d.wrAddr = instAddr;
                  s_d.wrData = aluBus.res;
                  s_d.prescClr = (instAddr == abx_pkg::TIMER_ADDR) &&
                                 s_q.prescAssigned;
               end
            end
            default: s_d.seq = abx_pkg::SEQ_RUN;
         endcase
      end
   end

   // ****************************************
   // state register
   // ****************************************

   // synchronous reset beats the enable so reset never stalls
   always_ff @(posedge core_clk) begin
      if (rst) begin
         s_q <= STATE_RST;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

endmodule

`default_nettype wire

// ==== testbench/abx_exec_checker.sv ====
/* port assertions for the exec block.
   assumes the ports of abx_exec; attached by the bind at the foot. */
`timescale 1ns/1ps
`default_nettype none
module abx_exec_checker (
   // clock and control
   input wire logic core_clk,
   input wire logic rst,
   input wire logic ce,
   // instruction
   input wire logic instValid,
   input wire logic instReady,
   input wire abx_pkg::abx_op_t instOp,
   input wire logic [7:0] instImm,
   input wire logic [6:0] instAddr,
   input wire logic instDest,
   input wire logic [2:0] instBit,
   // file side
   input wire logic [6:0] fileRdAddr,
   input wire logic [7:0] fileRdData,
   input wire logic fileIsIo,
   input wire logic [7:0] ioPinData,
   input wire logic fileWrEn,
   input wire logic [6:0] fileWrAddr,
   input wire logic [7:0] fileWrData,
   // sequencing and state
   input wire logic nopSlot,
   input wire logic skipPending,
   input wire logic prescClr,
   input wire logic [7:0] accOut,
   input wire logic carryOut,
   input wire logic zeroOut
);
   // ************
   // properties
   // ************
   // executed versus eaten by a pending skip
   wire logic go = instValid && instReady && ce && !skipPending;
   wire logic eat = instValid && instReady && ce && skipPending;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   property p_addImm;
      go && instOp == abx_pkg::ADD_IMMEDIATE_TO_ACC |=> zeroOut == (accOut == 8'h00) &&
         {carryOut, accOut} == {1'b0, $past(accOut)} + {1'b0, $past(instImm)};
   endproperty
   a_addImm: assert property (p_addImm) else $error("add immediate wrong");
   property p_andImm;
      go && instOp == abx_pkg::AND_IMMEDIATE_WITH_ACC |=>
         accOut == ($past(accOut) & $past(instImm)) && carryOut == $past(carryOut);
   endproperty
   a_andImm: assert property (p_andImm) else $error("and immediate wrong");
   property p_dest;
      go && instOp inside {abx_pkg::ADD_ACC_AND_REG, abx_pkg::AND_ACC_WITH_REG} && instDest
         |=> fileWrEn && fileWrAddr == $past(instAddr) && accOut == $past(accOut);
   endproperty
   a_dest: assert property (p_dest) else $error("destination wrong");
   property p_bitClr;
      go && instOp == abx_pkg::SINGLE_BIT_CLEAR && !fileIsIo |=> fileWrEn &&
         fileWrData == ($past(fileRdData) & ~(8'h01 << $past(instBit))) && zeroOut == $past(zeroOut);
   endproperty
   a_bitClr: assert property (p_bitClr) else $error("bit clear wrong");
   property p_bitSet;
      go && instOp == abx_pkg::SINGLE_BIT_SET && fileIsIo |=> fileWrEn &&
         fileWrData == ($past(ioPinData) | (8'h01 << $past(instBit)));
   endproperty
   a_bitSet: assert property (p_bitSet) else $error("bit set wrong");
   property p_skip;
      go && instOp inside {abx_pkg::TEST_SKIP_WHEN_ZERO, abx_pkg::TEST_SKIP_WHEN_ONE} && !fileIsIo
         |=> skipPending == ((($past(fileRdData) >> $past(instBit)) & 8'h01) ==
         {7'h00, $past(instOp[0])});
   endproperty
   a_skip: assert property (p_skip) else $error("skip decision wrong");
   // the pulse only clears at an edge where ce was high
   property p_eat;
      eat |=> nopSlot && !fileWrEn && !skipPending ##1 (!nopSlot || !$past(ce));
   endproperty
   a_eat: assert property (p_eat) else $error("discarded slot wrong");
   property p_presc;
      prescClr |-> fileWrEn && fileWrAddr == abx_pkg::TIMER_ADDR;
   endproperty
   a_presc: assert property (p_presc) else $error("prescaler clear wrong");
   property p_rdAddr;
      instValid |-> fileRdAddr == instAddr;
   endproperty
   a_rdAddr: assert property (p_rdAddr) else $error("file read address wrong");
endmodule
bind abx_exec abx_exec_checker u_chk (.*);
`default_nettype wire

// ==== testbench/abx_exec_bench.sv ====
/* self-checking bench: random instructions against a model, apb reads
   of the state, refusal while disabled. assumes the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module abx_exec_bench;
   // ************
   // signals
   // ************
   logic core_clk = 1'b0, rst = 1'b1, ce = 1'b1, instValid = 1'b0, instDest = 1'b0;
   logic fileIsIo = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   abx_pkg::abx_op_t instOp = abx_pkg::ADD_IMMEDIATE_TO_ACC;
   logic [7:0] instImm = 8'h00, fileRdData = 8'h00, ioPinData = 8'h00, paddr = 8'h00;
   logic [6:0] instAddr = 7'h00;
   logic [2:0] instBit = 3'h0;
   logic [31:0] pwdata = 32'h0;
   wire logic instReady, fileWrEn, nopSlot, skipPending, prescClr, carryOut, halfCarryOut;
   wire logic zeroOut, pready, pslverr;
   wire logic [6:0] fileRdAddr, fileWrAddr;
   wire logic [7:0] fileWrData, accOut;
   wire logic [31:0] prdata;
   // model state and the two note queues
   logic [7:0] mAcc = 8'h00;
   logic mC = 1'b0, mHc = 1'b0, mZ = 1'b0, mSkip = 1'b0, mPresc = 1'b0, tookD = 1'b0;
   logic [15:0] mSkips = 16'h0;
   logic [29:0] instQ[$];
   logic [32:0] apbQ[$];
   int seed = 63, fail_count = 0, n_compared = 0;
   // write fields only count while the strobe is up
   wire logic [29:0] instAct = {accOut, carryOut, halfCarryOut, zeroOut, fileWrEn,
      fileWrEn ? {fileWrAddr, fileWrData} : 15'h0, nopSlot, prescClr, skipPending};

   abx_exec DUT (.*);

   always #5 core_clk = ~core_clk;

   task automatic test_done;
      if (fail_count == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic checkInst(input logic [29:0] exp, input logic [29:0] act);
      n_compared++;
      if (exp !== act) begin
         fail_count++;
         $display("FAIL %0t instruction exp %h got %h", $time, exp, act);
      end
   endtask

   task automatic checkApb(input logic [32:0] exp, input logic [32:0] act);
      n_compared++;
      if (exp !== act) begin
         fail_count++;
         $display("FAIL %0t apb read exp %h got %h", $time, exp, act);
      end
   endtask

   // apb master: setup, access until pready, release for one cycle
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [32:0] exp);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      if (!w)
         apbQ.push_back(exp);
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask

   // random stream; ce drops at times, so the request is held on
   task automatic run(input int count);
      logic [31:0] r, q;
      logic [7:0] src, res, msk, opnd;
      logic [8:0] s;
      logic [6:0] a7;
      logic we, nop, io;
      abx_pkg::abx_op_t op;
      for (int i = 0; i < count; i++) begin
         r = $random(seed);
         q = $random(seed);
         op = abx_pkg::abx_op_t'(r[2:0]);
         a7 = r[11] ? abx_pkg::TIMER_ADDR : r[18:12];
         io = r[23] && op[2:1] != 2'b11;
         instOp <= op;
         instImm <= r[10:3];
         instAddr <= a7;
         instDest <= r[19];
         instBit <= r[22:20];
         fileIsIo <= io;
         fileRdData <= q[7:0];
         ioPinData <= q[15:8];
         instValid <= 1'b1;
         ce <= r[24];
         @(posedge core_clk);
         if (!r[24]) begin
            ce <= 1'b1;
            @(posedge core_clk);
         end
         opnd = io ? q[15:8] : q[7:0];
         src = op[0] ? opnd : r[10:3];
         msk = 8'h01 << r[22:20];
         we = 1'b0;
         nop = mSkip;
         res = mAcc;
         if (mSkip) begin
            mSkip = 1'b0;
            mSkips++;
         end else if (op[2:1] == 2'b00) begin
            s = {1'b0, mAcc} + {1'b0, src};
            mC = s[8];
            mHc = ({1'b0, mAcc[3:0]} + {1'b0, src[3:0]}) > 5'h0f;
            res = s[7:0];
            mZ = res == 8'h00;
         end else if (op[2:1] == 2'b01) begin
            res = mAcc & src;
            mZ = res == 8'h00;
         end else if (op[2:1] == 2'b10)
            res = op[0] ? opnd | msk : opnd & ~msk;
         else
            mSkip = ((q[7:0] & msk) != 8'h00) == op[0];
         if (!nop && op[2:1] != 2'b11) begin
            we = op[2] || (op[0] && r[19]);
            if (!we)
               mAcc = res;
         end
         instQ.push_back({mAcc, mC, mHc, mZ, we, we ? {a7, res} : 15'h0, nop,
            we && a7 == abx_pkg::TIMER_ADDR && mPresc, mSkip});
      end
      instValid <= 1'b0;
   endtask

   // watcher: apb data at the access edge, instructions half a cycle after the taking edge
   always @(posedge core_clk) begin
      tookD <= instValid && instReady && ce && !rst;
      if (psel && penable && pready === 1'b1 && !pwrite)
         checkApb(apbQ.pop_front(), {pslverr, prdata});
   end
   always @(negedge core_clk)
      if (tookD)
         checkInst(instQ.pop_front(), instAct);

   // main sequence
   initial begin
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      apb(1'b0, abx_pkg::REG_CTRL, 32'h0, 33'h1);
      apb(1'b0, 8'h10, 32'h0, {1'b1, 32'h0});
      apb(1'b1, abx_pkg::REG_ACC, 32'h5a, 33'h0);
      mAcc = 8'h5a;
      run(150);
      apb(1'b1, abx_pkg::REG_CTRL, 32'h3, 33'h0);
      mPresc = 1'b1;
      run(150);
      apb(1'b0, abx_pkg::REG_SKIPS, 32'h0, {17'h0, mSkips});
      apb(1'b0, abx_pkg::REG_FLAGS, 32'h0, {30'h0, mZ, mHc, mC});
      apb(1'b1, abx_pkg::REG_CTRL, 32'h0, 33'h0);
      // disabled: a held request must not be taken
      instValid <= 1'b1;
      repeat (4) @(posedge core_clk);
      instValid <= 1'b0;
      apb(1'b0, abx_pkg::REG_ACC, 32'h0, {25'h0, mAcc});
      test_done();
   end

   // watchdog, far beyond the several hundred cycles the run needs
   initial begin
      #200000;
      fail_count++;
      test_done();
   end
endmodule
`default_nettype wire
